// file: design/ucf_defines.svh
// Constants of the UART command framer: delimiters, packet kinds, limits.
// Assumes nothing; included by the package users by bare name.
`ifndef UCF_DEFINES_SVH
`define UCF_DEFINES_SVH

// Frame delimiters.
`define UCF_FRAME_START_BYTE 8'h02
`define UCF_FRAME_END_BYTE 8'h03

// Packet kind bytes.
`define UCF_HOST_REQUEST_KIND 8'h52
`define UCF_DEVICE_CONFIRM_KIND 8'h43
`define UCF_DEVICE_NOTICE_KIND 8'h69
`define UCF_HOST_REPLY_KIND 8'h72

// Largest payload the receiver accepts, in bytes; the transmitter does not check it.
`define UCF_MAX_LEN 16'h014D

// Opcode of the transport-enabled event; the value is arbitrary.
`define UCF_TL_ENABLED_OPCODE 8'h00

// Payload FIFO shape.
`define UCF_FIFO_WIDTH 8
`define UCF_FIFO_DEPTH 8

`endif

// file: design/ucf_pkg.sv
// Types shared by the UART command framer and its users.
// Assumes the constants of ucf_defines.svh.
package ucf_pkg;

    // Frame header as it travels between framer and firmware.
    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] opcode;
        logic [15:0] length;
    } ucf_hdr_type;

    // Outgoing frame request with its side effects.
    typedef struct packed {
        ucf_hdr_type hdr;
        logic raw_after;
        logic shut_after;
    } ucf_tx_req_type;

    // Transport power states.
    typedef enum logic [2:0] {
        TP_ON = 3'h0,
        TP_OFF = 3'h1,
        TP_WAKE = 3'h2,
        TP_ANNOUNCE = 3'h3,
        TP_DRAIN = 3'h4
    } ucf_tp_type;

    // Frame byte positions, shared by receiver and transmitter.
    typedef enum logic [3:0] {
        FR_IDLE = 4'h0,
        FR_START = 4'h1,
        FR_KIND = 4'h2,
        FR_OP = 4'h3,
        FR_LLO = 4'h4,
        FR_LHI = 4'h5,
        FR_SUM = 4'h6,
        FR_PAY = 4'h7,
        FR_END = 4'h8
    } ucf_pos_type;

endpackage

// file: design/ucf_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ucf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic o_empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit.
    assign o_empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign o_in_ready = !full;
    assign o_out_valid = !o_empty;
    assign o_out_data = mem_q[rd_q[AW-1:0]];
    assign push = i_in_valid && !full;
    assign pop = i_out_ready && !o_empty;

    // Storage write.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: design/ucf_framer.sv
// UART command framer with hardware wake-up of the transport.
// Assumes a byte-level UART on i_clk (50 MHz) and the host CTS pin asynchronous.
`include "ucf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ucf_framer (
    input wire logic i_clk,
    input wire logic i_rst,
    // UART receive byte stream.
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_break,
    // UART transmit byte stream.
    output logic o_txd_valid,
    output logic [7:0] o_txd_data,
    input wire logic i_txd_ready,
    // Flow control and wake pins.
    input wire logic i_cts_n,
    output logic o_rts_n,
    output logic o_host_wakeup_out,
    output logic o_uart_enable,
    output logic o_raw_mode,
    // Parsed requests to firmware.
    output logic o_req_valid,
    output ucf_pkg::ucf_hdr_type o_req_hdr,
    output logic o_req_pay_valid,
    output logic [7:0] o_req_pay_data,
    output logic o_req_done,
    output logic o_req_drop,
    // Raw received bytes in transparent mode.
    output logic o_raw_rx_valid,
    output logic [7:0] o_raw_rx_data,
    // Outgoing frame requests from firmware.
    input wire logic i_tx_valid,
    input wire ucf_pkg::ucf_tx_req_type i_tx_req,
    output logic o_tx_ready,
    // Outgoing payload or raw bytes.
    input wire logic i_pay_valid,
    input wire logic [7:0] i_pay_data,
    output logic o_pay_ready
);
    import ucf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // CTS synchroniser and edge detection.

    logic cts_m1_q;
    logic cts_m2_q;
    logic cts_m3_q;
    logic cts_n_q;
    logic cts_fall;

    // Three stages; the stable level moves only when stages two and three agree.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cts_m1_q <= 1'b1;
            cts_m2_q <= 1'b1;
            cts_m3_q <= 1'b1;
            cts_n_q <= 1'b1;
        end else begin
            cts_m1_q <= i_cts_n;
            cts_m2_q <= cts_m1_q;
            cts_m3_q <= cts_m2_q;
            if (cts_m2_q == cts_m3_q) begin
                cts_n_q <= cts_m3_q;
            end
        end
    end

    // A falling edge on the stable level.
    assign cts_fall = cts_n_q && (cts_m2_q == cts_m3_q) && !cts_m3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Payload FIFO in the transmit path.

    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;
    logic fifo_empty;

    ucf_fifo #(
        .WIDTH(`UCF_FIFO_WIDTH),
        .DEPTH(`UCF_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_pay_valid),
        .i_in_data(i_pay_data),
        .o_in_ready(o_pay_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop),
        .o_empty(fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit framer.

    ucf_tp_type tp_q;
    ucf_tp_type tp_d;
    ucf_pos_type tx_q;
    ucf_pos_type tx_d;
    ucf_tx_req_type treq_q;
    logic [15:0] tcnt_q;
    logic txv_q;
    logic [7:0] txb_q;
    logic raw_q;
    logic slot_free;
    logic take_fw;
    logic take_auto;
    logic emit;
    logic [7:0] emit_byte;
    logic [7:0] tx_sum;
    logic raw_emit;
    logic end_emit;
    ucf_tx_req_type auto_req;

    // Transport-enabled event raised by any wake-up.
    assign auto_req.hdr.kind = `UCF_DEVICE_CONFIRM_KIND;
    assign auto_req.hdr.opcode = `UCF_TL_ENABLED_OPCODE;
    assign auto_req.hdr.length = 16'h0000;
    assign auto_req.raw_after = 1'b0;
    assign auto_req.shut_after = 1'b0;

    // Output slot and frame acceptance.
    assign slot_free = !txv_q || i_txd_ready;
    assign take_auto = (tx_q == FR_IDLE) && (tp_q == TP_ANNOUNCE);
    assign take_fw = o_tx_ready && i_tx_valid;
    assign o_tx_ready = (tx_q == FR_IDLE) && (tp_q == TP_ON) && !raw_q && !txv_q;
    assign raw_emit = (tx_q == FR_IDLE) && raw_q && fifo_valid && slot_free;
    assign tx_sum = treq_q.hdr.kind + treq_q.hdr.opcode
                  + treq_q.hdr.length[7:0] + treq_q.hdr.length[15:8];

    // Byte chosen for each frame position.
    assign emit_byte = (tx_q == FR_START) ? `UCF_FRAME_START_BYTE :
                       (tx_q == FR_KIND) ? treq_q.hdr.kind :
                       (tx_q == FR_OP) ? treq_q.hdr.opcode :
                       (tx_q == FR_LLO) ? treq_q.hdr.length[7:0] :
                       (tx_q == FR_LHI) ? treq_q.hdr.length[15:8] :
                       (tx_q == FR_SUM) ? tx_sum :
                       (tx_q == FR_END) ? `UCF_FRAME_END_BYTE :
                       fifo_data;

    // A framed byte leaves when the slot is free and, at the payload position, payload is present.
    assign emit = (tx_q != FR_IDLE) && slot_free && ((tx_q != FR_PAY) || fifo_valid);
    assign end_emit = emit && (tx_q == FR_END);
    assign fifo_pop = (emit && (tx_q == FR_PAY)) || raw_emit;

    // Next frame position.
    always_comb begin
        tx_d = tx_q;
        unique case (tx_q)
            FR_IDLE: begin
                if (take_auto || take_fw) begin
                    tx_d = FR_START;
                end
            end
            FR_START: begin
                if (emit) tx_d = FR_KIND;
            end
            FR_KIND: begin
                if (emit) tx_d = FR_OP;
            end
            FR_OP: begin
                if (emit) tx_d = FR_LLO;
            end
            FR_LLO: begin
                if (emit) tx_d = FR_LHI;
            end
            FR_LHI: begin
                if (emit) tx_d = FR_SUM;
            end
            FR_SUM: begin
                if (emit) tx_d = (treq_q.hdr.length == 16'h0000) ? FR_END : FR_PAY;
            end
            FR_PAY: begin
                if (emit && (tcnt_q == 16'h0001)) tx_d = FR_END;
            end
            FR_END: begin
                if (emit) tx_d = FR_IDLE;
            end
            default: tx_d = FR_IDLE;
        endcase
    end

    // Frame position, header and payload count.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_q <= FR_IDLE;
            treq_q <= '0;
            tcnt_q <= 16'h0000;
        end else begin
            tx_q <= tx_d;
            if (take_auto) treq_q <= auto_req;
            else if (take_fw) treq_q <= i_tx_req;
            if (emit && (tx_q == FR_SUM)) tcnt_q <= treq_q.hdr.length;
            else if (fifo_pop && !raw_emit) tcnt_q <= tcnt_q - 16'h0001;
        end
    end

    // Registered UART output byte.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            txv_q <= 1'b0;
            txb_q <= 8'h00;
        end else if (emit || raw_emit) begin
            txv_q <= 1'b1;
            txb_q <= raw_emit ? fifo_data : emit_byte;
        end else if (i_txd_ready) begin
            txv_q <= 1'b0;
        end
    end

    assign o_txd_valid = txv_q;
    assign o_txd_data = txb_q;

    // Pass-through mode: entered after its confirm, left on a line break.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            raw_q <= 1'b0;
        end else if (end_emit && treq_q.raw_after) begin
            raw_q <= 1'b1;
        end else if (i_rx_break) begin
            raw_q <= 1'b0;
        end
    end

    assign o_raw_mode = raw_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Transport power and wake-up handshake.

    always_comb begin
        tp_d = tp_q;
        unique case (tp_q)
            TP_ON: begin
                if (end_emit && treq_q.shut_after) tp_d = TP_DRAIN;
            end
            TP_DRAIN: begin
                if (!txv_q && fifo_empty) tp_d = TP_OFF;
            end
            TP_OFF: begin
                if (cts_fall) tp_d = TP_ANNOUNCE;
                else if (i_tx_valid || fifo_valid) tp_d = TP_WAKE;
            end
            TP_WAKE: begin
                if (!cts_n_q) tp_d = TP_ANNOUNCE;
            end
            TP_ANNOUNCE: begin
                if (end_emit) tp_d = TP_ON;
            end
            default: tp_d = TP_ON;
        endcase
    end

    // Transport state.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tp_q <= TP_ON;
        end else begin
            tp_q <= tp_d;
        end
    end

    // Pin levels follow the transport state.
    assign o_rts_n = (tp_q == TP_OFF);
    assign o_host_wakeup_out = (tp_q == TP_WAKE) || (tp_q == TP_ANNOUNCE);
    assign o_uart_enable = (tp_q != TP_OFF) && (tp_q != TP_WAKE);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive parser.

    ucf_pos_type rx_q;
    ucf_pos_type rx_d;
    ucf_hdr_type rhdr_q;
    logic [7:0] rsum_q;
    logic [15:0] rcnt_q;
    logic rx_take;
    logic rx_framed;
    logic sum_ok;
    logic len_ok;
    logic req_valid_q;
    logic pay_valid_q;
    logic [7:0] pay_data_q;
    logic done_q;
    logic drop_q;
    logic rawv_q;
    logic [7:0] rawb_q;

    // Bytes count only while the transport is up.
    assign rx_take = i_rx_valid && ((tp_q == TP_ON) || (tp_q == TP_DRAIN));
    assign rx_framed = rx_take && !raw_q;
    assign sum_ok = (rsum_q == i_rx_data);
    assign len_ok = (rhdr_q.length <= `UCF_MAX_LEN);

    // Next parse position; a fault returns to the start-byte hunt.
    always_comb begin
        rx_d = rx_q;
        if (rx_framed) begin
            unique case (rx_q)
                FR_IDLE: begin
                    if (i_rx_data == `UCF_FRAME_START_BYTE) rx_d = FR_KIND;
                end
                FR_KIND: rx_d = FR_OP;
                FR_OP: rx_d = FR_LLO;
                FR_LLO: rx_d = FR_LHI;
                FR_LHI: rx_d = FR_SUM;
                FR_SUM: begin
                    if (!sum_ok || !len_ok) rx_d = FR_IDLE;
                    else rx_d = (rhdr_q.length == 16'h0000) ? FR_END : FR_PAY;
                end
                FR_PAY: begin
                    if (rcnt_q == 16'h0001) rx_d = FR_END;
                end
                FR_END: rx_d = FR_IDLE;
                default: rx_d = FR_IDLE;
            endcase
        end
    end

    // Header capture and running sum.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_q <= FR_IDLE;
            rhdr_q <= '0;
            rsum_q <= 8'h00;
            rcnt_q <= 16'h0000;
        end else begin
            rx_q <= rx_d;
            if (rx_framed) begin
                unique case (rx_q)
                    FR_IDLE: rsum_q <= 8'h00;
                    FR_KIND: begin
                        rhdr_q.kind <= i_rx_data;
                        rsum_q <= rsum_q + i_rx_data;
                    end
                    FR_OP: begin
                        rhdr_q.opcode <= i_rx_data;
                        rsum_q <= rsum_q + i_rx_data;
                    end
                    FR_LLO: begin
                        rhdr_q.length[7:0] <= i_rx_data;
                        rsum_q <= rsum_q + i_rx_data;
                    end
                    FR_LHI: begin
                        rhdr_q.length[15:8] <= i_rx_data;
                        rsum_q <= rsum_q + i_rx_data;
                    end
                    FR_SUM: rcnt_q <= rhdr_q.length;
                    FR_PAY: rcnt_q <= rcnt_q - 16'h0001;
                    default: rsum_q <= rsum_q;
                endcase
            end
        end
    end

    // Registered pulses and data toward firmware.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_valid_q <= 1'b0;
            pay_valid_q <= 1'b0;
            pay_data_q <= 8'h00;
            done_q <= 1'b0;
            drop_q <= 1'b0;
            rawv_q <= 1'b0;
            rawb_q <= 8'h00;
        end else begin
            req_valid_q <= rx_framed && (rx_q == FR_SUM) && sum_ok && len_ok;
            pay_valid_q <= rx_framed && (rx_q == FR_PAY);
            if (rx_take) pay_data_q <= i_rx_data;
            done_q <= rx_framed && (rx_q == FR_END) && (i_rx_data == `UCF_FRAME_END_BYTE);
            drop_q <= rx_framed && (((rx_q == FR_SUM) && !(sum_ok && len_ok))
                   || ((rx_q == FR_END) && (i_rx_data != `UCF_FRAME_END_BYTE)));
            rawv_q <= rx_take && raw_q;
            if (rx_take) rawb_q <= i_rx_data;
        end
    end

    assign o_req_valid = req_valid_q;
    assign o_req_hdr = rhdr_q;
    assign o_req_pay_valid = pay_valid_q;
    assign o_req_pay_data = pay_data_q;
    assign o_req_done = done_q;
    assign o_req_drop = drop_q;
    assign o_raw_rx_valid = rawv_q;
    assign o_raw_rx_data = rawb_q;
endmodule
`default_nettype wire

// file: verif/ucf_framer_sva.sv
// Checker of the UART command framer ports: framing, raw mode and wake pins.
// Assumes one clock and a synchronous active-high reset; bound in the bench.
`timescale 1ns/1ps
`default_nettype none
module ucf_framer_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_break,
    input wire logic o_txd_valid,
    input wire logic [7:0] o_txd_data,
    input wire logic i_txd_ready,
    input wire logic o_rts_n,
    input wire logic o_host_wakeup_out,
    input wire logic o_uart_enable,
    input wire logic o_raw_mode,
    input wire logic o_req_valid,
    input wire ucf_pkg::ucf_hdr_type o_req_hdr,
    input wire logic o_raw_rx_valid,
    input wire logic [7:0] o_raw_rx_data,
    input wire logic i_tx_valid,
    input wire logic o_tx_ready
);
    import ucf_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Each taken request opens its frame with the start byte two cycles later.
    tx_take_a: assert property (i_tx_valid && o_tx_ready |-> ##2 o_txd_valid && o_txd_data == 8'h02)
        else $error("no start byte");
    // A stalled byte stays on the line unchanged.
    txd_hold_a: assert property (o_txd_valid && !i_txd_ready |=> o_txd_valid && $stable(o_txd_data))
        else $error("stalled byte changed");
    // An accepted header had a matching sum byte and a legal length.
    req_sum_a: assert property (o_req_valid |-> $past(i_rx_data) == 8'(o_req_hdr.kind + o_req_hdr.opcode
        + o_req_hdr.length[7:0] + o_req_hdr.length[15:8]) && o_req_hdr.length <= 16'h014D)
        else $error("bad header accepted");
    // Pass-through forwards each byte and never parses it.
    raw_pass_a: assert property (o_raw_mode && i_rx_valid |=> o_raw_rx_valid && !o_req_valid
        && o_raw_rx_data == $past(i_rx_data))
        else $error("raw byte lost");
    // No framed request is taken during pass-through.
    raw_refuse_a: assert property (o_raw_mode |-> !o_tx_ready)
        else $error("frame taken in raw");
    // A break leaves pass-through.
    break_exit_a: assert property (o_raw_mode && i_rx_break |=> !o_raw_mode)
        else $error("break ignored");
    // With the transport off the UART and wake output are quiet.
    off_quiet_a: assert property (o_rts_n |-> !o_uart_enable && !o_host_wakeup_out)
        else $error("uart on while off");
    // Leaving the off state always raises the wake output with RTS.
    wake_ack_a: assert property ($fell(o_rts_n) |-> o_host_wakeup_out)
        else $error("rts without wake");
    // Pending transmit work while off wakes the host within three cycles.
    dev_wake_a: assert property (o_rts_n && i_tx_valid |-> ##[1:3] !o_rts_n && o_host_wakeup_out)
        else $error("host not woken");
endmodule
`default_nettype wire

// file: verif/ucf_host_model.sv
// Host side model: takes UART bytes with stalls and drives its RTS pin.
// Assumes the bench tells it when the host sleeps or wants to wake.
`timescale 1ns/1ps
`default_nettype none
module ucf_host_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_txd_valid,
    input wire logic [7:0] i_txd_data,
    output logic o_txd_ready,
    input wire logic i_host_wakeup_out,
    input wire logic i_asleep,
    input wire logic i_wake,
    output logic o_cts_n,
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    logic [1:0] stall_q;
    // Ready drops one cycle in three so the framer must hold its byte.
    assign o_txd_ready = (stall_q != 2'h2);
    // Stall counter, byte hand-over and the host RTS pin.
    always_ff @(posedge i_clk) begin
        stall_q <= (i_rst || stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
        o_byte_valid <= !i_rst && i_txd_valid && o_txd_ready;
        o_byte <= i_txd_data;
        o_cts_n <= !i_rst && i_asleep && !i_wake && !i_host_wakeup_out;
    end
endmodule
`default_nettype wire

// file: verif/test_ucf_framer.sv
// Self-checking bench of the UART command framer: frame table, then awkward cases.
// Assumes ucf_host_model as the host and ucf_framer_sva bound to the framer.
`include "ucf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ucf_framer;
    import ucf_pkg::*;
    typedef struct packed {
        logic host;
        ucf_hdr_type hdr;
        logic [7:0] sum;
    } ucf_row_type;
    logic i_clk = 0, i_rst = 1, i_rx_valid = 0, i_rx_break = 0, i_tx_valid = 0, i_pay_valid = 0;
    logic [7:0] i_rx_data = 0, i_pay_data = 0, o_txd_data, o_req_pay_data, o_raw_rx_data, hbyte;
    logic i_txd_ready, i_cts_n, o_txd_valid, o_rts_n, o_host_wakeup_out, o_uart_enable, o_raw_mode;
    logic o_req_valid, o_req_pay_valid, o_req_done, o_req_drop, o_raw_rx_valid, o_tx_ready;
    logic o_pay_ready, hvalid, asleep = 0, wake = 0;
    ucf_hdr_type o_req_hdr, last_hdr;
    ucf_tx_req_type i_tx_req = '0;
    logic [7:0] got [$], exp [$];
    int failures = 0, samples_checked = 0, cycles = 0;
    int n_req = 0, n_pay = 0, n_done = 0, n_drop = 0, n_raw = 0, a, b, c, d, e;
    // Host requests carry 0x52, replies 0x72; device frames 0x43 and 0x69.
    ucf_row_type rows [5] = '{
        '{1'b0, '{8'h43, 8'h11, 16'h0000}, 8'h54},
        '{1'b0, '{8'h69, 8'h22, 16'h0003}, 8'h8E},
        '{1'b0, '{8'h43, 8'hFF, 16'h014D}, 8'h90},
        '{1'b1, '{8'h52, 8'h33, 16'h0002}, 8'h87},
        '{1'b1, '{8'h72, 8'h44, 16'h014D}, 8'h04}};
    ////////////////////////////////////////////////////////////////////////////
    ucf_framer ucf_framer_i (.i_clk, .i_rst, .i_rx_valid, .i_rx_data, .i_rx_break, .o_txd_valid,
        .o_txd_data, .i_txd_ready, .i_cts_n, .o_rts_n, .o_host_wakeup_out, .o_uart_enable,
        .o_raw_mode, .o_req_valid, .o_req_hdr, .o_req_pay_valid, .o_req_pay_data, .o_req_done,
        .o_req_drop, .o_raw_rx_valid, .o_raw_rx_data, .i_tx_valid, .i_tx_req, .o_tx_ready,
        .i_pay_valid, .i_pay_data, .o_pay_ready);
    ucf_host_model ucf_host_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_txd_valid(o_txd_valid),
        .i_txd_data(o_txd_data), .o_txd_ready(i_txd_ready), .i_host_wakeup_out(o_host_wakeup_out),
        .i_asleep(asleep), .i_wake(wake), .o_cts_n(i_cts_n), .o_byte_valid(hvalid), .o_byte(hbyte));
    ////////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // Collect host bytes and count framer pulses; cut a hang short.
    always @(posedge i_clk) begin
        if (hvalid === 1'b1) got.push_back(hbyte);
        if (o_req_valid === 1'b1) last_hdr = o_req_hdr;
        n_req += (o_req_valid === 1'b1);
        n_pay += (o_req_pay_valid === 1'b1);
        n_done += (o_req_done === 1'b1);
        n_drop += (o_req_drop === 1'b1);
        n_raw += (o_raw_rx_valid === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d values, %0d wrong", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic snap();
        a = n_req;
        b = n_pay;
        c = n_done;
        d = n_drop;
        e = n_raw;
    endtask
    task automatic rx(input logic [7:0] v);
        i_rx_valid = 1;
        i_rx_data = v;
        tick(1);
        i_rx_valid = 0;
        tick(1);
    endtask
    // Host frame: start, kind, opcode, length low then high, sum, payload, end.
    task automatic rx_frame(input ucf_hdr_type h, input logic [7:0] s, input int n);
        rx(8'h02);
        rx(h.kind);
        rx(h.opcode);
        rx(h.length[7:0]);
        rx(h.length[15:8]);
        rx(s);
        for (int i = 0; i < n; i++) rx(8'(i));
        rx(8'h03);
    endtask
    task automatic tx(input ucf_hdr_type h, input logic raw, input logic shut);
        i_tx_valid = 1;
        i_tx_req = '{h, raw, shut};
        do @(negedge i_clk); while (o_tx_ready !== 1'b1);
        tick(1);
        i_tx_valid = 0;
    endtask
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            i_pay_valid = 1;
            i_pay_data = 8'(i);
            do @(negedge i_clk); while (o_pay_ready !== 1'b1);
            tick(1);
        end
        i_pay_valid = 0;
    endtask
    task automatic want_frame(input ucf_hdr_type h, input logic [7:0] s);
        exp = {exp, `UCF_FRAME_START_BYTE, h.kind, h.opcode, h.length[7:0], h.length[15:8], s};
        for (int i = 0; i < int'(h.length); i++) exp.push_back(8'(i));
        exp.push_back(`UCF_FRAME_END_BYTE);
    endtask
    // Expected frame, then request and payload side by side.
    task automatic send(input ucf_hdr_type h, input logic [7:0] s, input logic raw,
        input logic shut);
        want_frame(h, s);
        fork
            tx(h, raw, shut);
            push(int'(h.length));
        join
    endtask
    task automatic drain(input string what);
        wait (got.size() >= exp.size());
        tick(4);
        check(what, got.size(), exp.size());
        foreach (exp[i]) check(what, got[i], exp[i]);
        got.delete();
        exp.delete();
    endtask
    task automatic shut_down();
        send('{8'h43, 8'h66, 16'h0000}, 8'hA9, 1'b0, 1'b1);
        drain("shut confirm");
        tick(10);
        check("off pins", {o_rts_n, o_uart_enable}, 2'b10);
        asleep = 1;
        tick(10);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, frame table, bad frames, pass-through, wake-ups.
    initial begin
        tick(20);
        i_rst = 0;
        check("reset outs", {o_rts_n, o_host_wakeup_out, o_uart_enable, o_txd_valid, o_raw_mode,
            o_tx_ready, o_pay_ready}, 7'b0010011);
        $display("test reset done");
        foreach (rows[r]) begin
            snap();
            if (rows[r].host) begin
                rx_frame(rows[r].hdr, rows[r].sum, int'(rows[r].hdr.length));
                tick(2);
                check("req hdr", last_hdr, rows[r].hdr);
                check("req counts", {n_req - a, n_pay - b, n_done - c},
                    {1, int'(rows[r].hdr.length), 1});
            end else begin
                send(rows[r].hdr, rows[r].sum, 1'b0, 1'b0);
                drain("tx frame");
            end
            $display("test row %0d done", r);
        end
        snap();
        rx(8'h55);
        rx_frame('{8'h52, 8'h33, 16'h0002}, 8'h00, 2);
        rx_frame('{8'h52, 8'h33, 16'h014E}, 8'hD4, 0);
        rx_frame(rows[3].hdr, rows[3].sum, 2);
        tick(2);
        check("bad frames", {n_req - a, n_done - c, n_drop - d}, {1, 1, 2});
        $display("test bad frames done");
        send('{8'h43, 8'h55, 16'h0000}, 8'h98, 1'b1, 1'b0);
        drain("raw confirm");
        check("raw on", o_raw_mode, 1'b1);
        snap();
        rx(8'h02);
        rx(8'h52);
        check("raw rx", {n_raw - e, n_req - a}, {2, 0});
        exp = '{8'h00, 8'h01};
        push(2);
        drain("raw tx");
        i_rx_break = 1;
        tick(1);
        i_rx_break = 0;
        tick(1);
        check("raw off", o_raw_mode, 1'b0);
        $display("test pass-through done");
        shut_down();
        want_frame('{8'h43, `UCF_TL_ENABLED_OPCODE, 16'h0000}, 8'h43);
        wake = 1;
        drain("host wake");
        wake = 0;
        asleep = 0;
        check("awake pins", {o_rts_n, o_host_wakeup_out, o_uart_enable}, 3'b001);
        $display("test host wake done");
        shut_down();
        want_frame('{8'h43, `UCF_TL_ENABLED_OPCODE, 16'h0000}, 8'h43);
        send('{8'h69, 8'h77, 16'h0001}, 8'hE1, 1'b0, 1'b0);
        drain("device wake");
        asleep = 0;
        check("woken pins", {o_rts_n, o_uart_enable}, 2'b01);
        $display("test device wake done");
        close_out();
    end
endmodule
bind ucf_framer ucf_framer_sva ucf_framer_sva_i (.i_clk, .i_rst, .i_rx_valid, .i_rx_data,
    .i_rx_break, .o_txd_valid, .o_txd_data, .i_txd_ready, .o_rts_n, .o_host_wakeup_out,
    .o_uart_enable, .o_raw_mode, .o_req_valid, .o_req_hdr, .o_raw_rx_valid, .o_raw_rx_data,
    .i_tx_valid, .o_tx_ready);
`default_nettype wire
